// ===== rtl/full_bandwidth_channel_test.sv
// full-bandwidth channel test control with register port and channel sequencer
`timescale 1ns/100ps

// Behaviour
// RULE1 - the test runs only while the unlock word of the control register holds 1101.
// RULE2 - any other unlock word keeps the test off and the channel outputs idle for normal use.
// RULE3 - when enabled, all 128 channels are fed in turn from the pseudo random generator or the streamed slots.
// RULE4 - the streamed source is the symbol port chosen by the port field, 00 A, 01 B, 10 C, 11 D.
// RULE5 - the streamed source is the group of 8 timeslots chosen by the slot group field, 00 for 1 to 8 up to 11 for 25 to 32.
// RULE6 - after reset the control register reads zero, so the test is off with port A and slot group one chosen.
module full_bandwidth_channel_test
(
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// register port
	input wire logic [fbt_pkg::ADDR_W-1:0] ADDR,
	input wire logic [fbt_pkg::DATA_W-1:0] WR_DATA,
	input wire logic WR_EN,
	input wire logic RD_EN,
	output logic [fbt_pkg::DATA_W-1:0] RD_DATA,
	// symbol port A
	input wire logic [fbt_pkg::SYM_W-1:0] SYM_DATA_A,
	input wire logic [fbt_pkg::SLOT_W-1:0] SYM_SLOT_A,
	input wire logic SYM_VALID_A,
	// symbol port B
	input wire logic [fbt_pkg::SYM_W-1:0] SYM_DATA_B,
	input wire logic [fbt_pkg::SLOT_W-1:0] SYM_SLOT_B,
	input wire logic SYM_VALID_B,
	// symbol port C
	input wire logic [fbt_pkg::SYM_W-1:0] SYM_DATA_C,
	input wire logic [fbt_pkg::SLOT_W-1:0] SYM_SLOT_C,
	input wire logic SYM_VALID_C,
	// symbol port D
	input wire logic [fbt_pkg::SYM_W-1:0] SYM_DATA_D,
	input wire logic [fbt_pkg::SLOT_W-1:0] SYM_SLOT_D,
	input wire logic SYM_VALID_D,
	// test channel stream towards the modulator
	output logic TEST_ACTIVE,
	output logic CH_VALID,
	output logic [fbt_pkg::CHAN_W-1:0] CH_INDEX,
	output logic [fbt_pkg::SYM_W-1:0] CH_SYMBOL
);
	import fbt_pkg::*;

	localparam int PIN_W = SYM_W + SLOT_W + 1;

	// synchronised port samples
	logic [PIN_W-1:0] pin_raw [PORT_COUNT];
	logic [PIN_W-1:0] pin_meta_reg [PORT_COUNT];
	logic [PIN_W-1:0] pin_sync_reg [PORT_COUNT];

	// registers and their next values
	logic [DATA_W-1:0] ctrl_reg;
	logic [DATA_W-1:0] ctrl_next;
	logic [DATA_W-1:0] source_reg;
	logic [DATA_W-1:0] source_next;
	logic [DATA_W-1:0] rd_data_reg;
	logic [DATA_W-1:0] rd_data_next;
	test_state_type state_reg;
	test_state_type state_next;
	logic [GROUP_SLOTS-1:0] fill_reg;
	logic [GROUP_SLOTS-1:0] fill_next;
	logic [CHAN_W-1:0] chan_reg;
	logic [CHAN_W-1:0] chan_next;
	logic [PSEUDO_RANDOM_SEQUENCE_W-1:0] pseudo_random_sequence_reg;
	logic [PSEUDO_RANDOM_SEQUENCE_W-1:0] pseudo_random_sequence_next;
	logic pipe_valid_reg;
	logic pipe_valid_next;
	logic [CHAN_W-1:0] pipe_chan_reg;
	logic [CHAN_W-1:0] pipe_chan_next;
	logic [SYM_W-1:0] pipe_pseudo_random_sequence_reg;
	logic [SYM_W-1:0] pipe_pseudo_random_sequence_next;
	logic pipe_stream_reg;
	logic pipe_stream_next;
	logic active_reg;
	logic active_next;
	logic ch_valid_reg;
	logic ch_valid_next;
	logic [CHAN_W-1:0] ch_index_reg;
	logic [CHAN_W-1:0] ch_index_next;
	logic [SYM_W-1:0] ch_symbol_reg;
	logic [SYM_W-1:0] ch_symbol_next;

	// decoded controls
	logic unlocked;
	logic stream_mode;
	logic [1:0] port_sel;
	logic [1:0] group_sel;
	logic cfg_write;
	logic [PIN_W-1:0] sel_pin;
	logic cap_hit;
	logic cap_en;
	logic [GROUP_W-1:0] cap_addr;
	logic [SYM_W-1:0] cap_data;
	logic [SYM_W-1:0] buf_rd_data;

	// gather the four ports so one loop handles them
	assign pin_raw[0] = {SYM_VALID_A, SYM_SLOT_A, SYM_DATA_A};
	assign pin_raw[1] = {SYM_VALID_B, SYM_SLOT_B, SYM_DATA_B};
	assign pin_raw[2] = {SYM_VALID_C, SYM_SLOT_C, SYM_DATA_C};
	assign pin_raw[3] = {SYM_VALID_D, SYM_SLOT_D, SYM_DATA_D};

	// two-stage synchroniser on every port pin
	for (genvar p = 0; p < PORT_COUNT; p++)
	begin : g_port_sync
		always_ff @(posedge MCLK or negedge RST_N)
		begin
			if (!RST_N)
			begin
				pin_meta_reg[p] <= '0;
				pin_sync_reg[p] <= '0;
			end
			else
			begin
				pin_meta_reg[p] <= pin_raw[p];
				pin_sync_reg[p] <= pin_meta_reg[p];
			end
		end
	end

	// field decode of the control registers
	always_comb
	begin
		unlocked = (ctrl_reg[UNLOCK_LSB +: 4] == UNLOCK_CODE); // RULE1 RULE2
		port_sel = ctrl_reg[PORT_LSB +: 2];
		group_sel = ctrl_reg[GROUP_LSB +: 2];
		stream_mode = source_reg[SOURCE_BIT];
		cfg_write = WR_EN && ((ADDR == TEST_CTRL_OFFSET) || (ADDR == SOURCE_CTRL_OFFSET));
	end

	// capture of the chosen port and slot group
	always_comb
	begin
		sel_pin = pin_sync_reg[port_sel]; // RULE4
		cap_hit = sel_pin[PIN_W-1] && (sel_pin[SYM_W + GROUP_W +: 2] == group_sel); // RULE5
		cap_en = cap_hit && unlocked && stream_mode && (state_reg != ST_IDLE);
		cap_addr = sel_pin[SYM_W +: GROUP_W];
		cap_data = sel_pin[SYM_W-1:0];
	end

	// register writes and read data
	always_comb
	begin
		ctrl_next = ctrl_reg;
		source_next = source_reg;
		rd_data_next = '0;
		if (WR_EN)
		begin
			if (ADDR == TEST_CTRL_OFFSET)
			begin
				ctrl_next = WR_DATA & TEST_CTRL_MASK;
			end
			else if (ADDR == SOURCE_CTRL_OFFSET)
			begin
				source_next = {{(DATA_W-1){1'b0}}, WR_DATA[SOURCE_BIT]};
			end
		end
		if (RD_EN)
		begin
			if (ADDR == TEST_CTRL_OFFSET)
			begin
				rd_data_next = ctrl_reg;
			end
			else if (ADDR == SOURCE_CTRL_OFFSET)
			begin
				rd_data_next = source_reg;
			end
			else if (ADDR == STATUS_OFFSET)
			begin
				rd_data_next[STAT_ACTIVE_BIT] = active_reg;
				rd_data_next[STAT_STATE_LSB +: 2] = state_reg;
				rd_data_next[STAT_FILL_LSB +: GROUP_SLOTS] = fill_reg;
			end
		end
	end

	// register storage
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ctrl_reg <= TEST_CTRL_RESET; // RULE6
			source_reg <= SOURCE_CTRL_RESET;
			rd_data_reg <= '0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			source_reg <= source_next;
			rd_data_reg <= rd_data_next;
		end
	end

	// test sequencer: idle, fill the slot buffer in stream mode, then run all channels
	always_comb
	begin
		state_next = state_reg;
		fill_next = fill_reg;
		chan_next = chan_reg;
		pseudo_random_sequence_next = pseudo_random_sequence_reg;
		case (state_reg)
			ST_IDLE:
			begin
				fill_next = '0;
				chan_next = '0;
				pseudo_random_sequence_next = PSEUDO_RANDOM_SEQUENCE_SEED;
				if (unlocked) // RULE1
				begin
					state_next = stream_mode ? ST_FILL : ST_RUN;
				end
			end
			ST_FILL:
			begin
				if (cap_en)
				begin
					fill_next[cap_addr] = 1'b1;
				end
				if (&fill_reg)
				begin
					state_next = ST_RUN;
				end
			end
			ST_RUN:
			begin
				chan_next = chan_reg + 1'b1; // RULE3
				pseudo_random_sequence_next = {pseudo_random_sequence_reg[PSEUDO_RANDOM_SEQUENCE_W-2:0], pseudo_random_sequence_reg[PSEUDO_RANDOM_SEQUENCE_W-1] ^ pseudo_random_sequence_reg[PSEUDO_RANDOM_SEQUENCE_W-2]};
			end
			default:
			begin
				state_next = ST_IDLE;
			end
		endcase
		// leaving the code or changing the setup restarts from idle
		if (!unlocked || cfg_write) // RULE2
		begin
			state_next = ST_IDLE;
		end
	end

	// sequencer storage
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state_reg <= ST_IDLE;
			fill_reg <= '0;
			chan_reg <= '0;
			pseudo_random_sequence_reg <= PSEUDO_RANDOM_SEQUENCE_SEED;
		end
		else
		begin
			state_reg <= state_next;
			fill_reg <= fill_next;
			chan_reg <= chan_next;
			pseudo_random_sequence_reg <= pseudo_random_sequence_next;
		end
	end

	// slot buffer, one entry per timeslot of the group
	slot_buffer
	#(
		.WIDTH(SYM_W),
		.DEPTH(GROUP_SLOTS),
		.AW(GROUP_W)
	)
	u_slot_buffer
	(
		.clk(MCLK),
		.rst_n(RST_N),
		.wr_en(cap_en),
		.wr_addr(cap_addr),
		.wr_data(cap_data),
		.rd_addr(chan_reg[GROUP_W-1:0]),
		.rd_data(buf_rd_data)
	);

	// output pipeline matching the buffer read latency
	always_comb
	begin
		pipe_valid_next = (state_reg == ST_RUN) && unlocked && !cfg_write; // RULE3
		pipe_chan_next = chan_reg;
		pipe_pseudo_random_sequence_next = pseudo_random_sequence_reg[SYM_W-1:0];
		pipe_stream_next = stream_mode;
		active_next = unlocked; // RULE1 RULE2
		ch_valid_next = pipe_valid_reg && unlocked;
		ch_index_next = pipe_valid_reg ? pipe_chan_reg : '0;
		ch_symbol_next = '0;
		if (pipe_valid_reg)
		begin
			ch_symbol_next = pipe_stream_reg ? buf_rd_data : pipe_pseudo_random_sequence_reg; // RULE3
		end
	end

	// output pipeline storage
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pipe_valid_reg <= 1'b0;
			pipe_chan_reg <= '0;
			pipe_pseudo_random_sequence_reg <= '0;
			pipe_stream_reg <= 1'b0;
			active_reg <= 1'b0;
			ch_valid_reg <= 1'b0;
			ch_index_reg <= '0;
			ch_symbol_reg <= '0;
		end
		else
		begin
			pipe_valid_reg <= pipe_valid_next;
			pipe_chan_reg <= pipe_chan_next;
			pipe_pseudo_random_sequence_reg <= pipe_pseudo_random_sequence_next;
			pipe_stream_reg <= pipe_stream_next;
			active_reg <= active_next;
			ch_valid_reg <= ch_valid_next;
			ch_index_reg <= ch_index_next;
			ch_symbol_reg <= ch_symbol_next;
		end
	end

	// outputs straight from flip-flops
	assign RD_DATA = rd_data_reg;
	assign TEST_ACTIVE = active_reg;
	assign CH_VALID = ch_valid_reg;
	assign CH_INDEX = ch_index_reg;
	assign CH_SYMBOL = ch_symbol_reg;
endmodule

// ===== rtl/fbt_pkg.sv
// constants and types shared by the full-bandwidth channel test block
package fbt_pkg;
	// bus and datapath widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 16;
	localparam int SYM_W = 10;
	localparam int SLOT_W = 5;
	localparam int PORT_COUNT = 4;
	localparam int CHAN_COUNT = 128;
	localparam int CHAN_W = 7;
	localparam int GROUP_SLOTS = 8;
	localparam int GROUP_W = 3;
	localparam int PSEUDO_RANDOM_SEQUENCE_W = 15;

	// register offsets
	localparam logic [ADDR_W-1:0] TEST_CTRL_OFFSET = 12'h003;
	localparam logic [ADDR_W-1:0] SOURCE_CTRL_OFFSET = 12'h004;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h005;

	// values after reset
	localparam logic [DATA_W-1:0] TEST_CTRL_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] SOURCE_CTRL_RESET = 16'h0000;
	localparam logic [PSEUDO_RANDOM_SEQUENCE_W-1:0] PSEUDO_RANDOM_SEQUENCE_SEED = 15'h7fff;

	// field positions in the test control register
	localparam int UNLOCK_LSB = 12;
	localparam int PORT_LSB = 2;
	localparam int GROUP_LSB = 0;
	localparam logic [DATA_W-1:0] TEST_CTRL_MASK = 16'hf00f;
	localparam logic [3:0] UNLOCK_CODE = 4'hd;

	// field positions in the source and status registers
	localparam int SOURCE_BIT = 0;
	localparam int STAT_ACTIVE_BIT = 0;
	localparam int STAT_STATE_LSB = 1;
	localparam int STAT_FILL_LSB = 3;

	// test sequencing states
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_FILL = 2'b01,
		ST_RUN = 2'b10
	} test_state_type;
endpackage

// ===== rtl/slot_buffer.sv
// small buffer holding the symbols of one captured timeslot group
`timescale 1ns/100ps
module slot_buffer
#(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8,
	parameter int AW = 3
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// read side, data one cycle after address
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	// storage array, no reset needed
	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	// registered read port
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_data <= '0;
		end
		else
		begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// ===== testbench/fbt_checker_assertions.sv
// port assertions for the full-bandwidth channel test block
`timescale 1ns/100ps
module fbt_checker
(
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// register port
	input wire logic [fbt_pkg::ADDR_W-1:0] ADDR,
	input wire logic [fbt_pkg::DATA_W-1:0] WR_DATA,
	input wire logic WR_EN,
	input wire logic RD_EN,
	input wire logic [fbt_pkg::DATA_W-1:0] RD_DATA,
	// channel stream
	input wire logic TEST_ACTIVE,
	input wire logic CH_VALID,
	input wire logic [fbt_pkg::CHAN_W-1:0] CH_INDEX,
	input wire logic [fbt_pkg::SYM_W-1:0] CH_SYMBOL
);
	import fbt_pkg::*;
	logic [DATA_W-1:0] ctl_reg;
	logic [DATA_W-1:0] ctl_next;
	logic unlocked;
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);
	// mirror of the control register
	always_comb
	begin
		ctl_next = ctl_reg;
		if (WR_EN && ADDR == TEST_CTRL_OFFSET)
		begin
			ctl_next = WR_DATA & 16'hf00f;
		end
	end
	// mirror storage
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ctl_reg <= 16'h0000;
		end
		else
		begin
			ctl_reg <= ctl_next;
		end
	end
	assign unlocked = ctl_reg[15:12] == 4'hd;
	a_unlock_enables: assert property (TEST_ACTIVE == $past(unlocked))
		else $error("active flag does not follow unlock word");
	a_lock_stops: assert property (!unlocked |-> ##2 !CH_VALID)
		else $error("channels run while locked");
	a_idle_zero: assert property (!CH_VALID |-> CH_INDEX == 7'h00 && CH_SYMBOL == 10'h000)
		else $error("idle channel outputs not zero");
	a_first_channel: assert property ($rose(CH_VALID) |-> CH_INDEX == 7'h00)
		else $error("run does not start at channel zero");
	a_index_steps: assert property (CH_VALID && $past(CH_VALID) |-> CH_INDEX == $past(CH_INDEX) + 7'h01)
		else $error("channel index skipped");
	a_run_holds: assert property (CH_VALID && !WR_EN && !$past(WR_EN) |=> CH_VALID)
		else $error("run stopped without a write");
	a_read_back: assert property (RD_EN && ADDR == TEST_CTRL_OFFSET |=> RD_DATA == $past(ctl_reg))
		else $error("control read back wrong");
	c_wrap: cover property (CH_VALID && CH_INDEX == 7'h7f);
	c_active: cover property ($rose(TEST_ACTIVE));
	c_read: cover property (RD_EN && ADDR == TEST_CTRL_OFFSET);
endmodule

bind full_bandwidth_channel_test fbt_checker chk (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WR_DATA(WR_DATA),
	.WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .TEST_ACTIVE(TEST_ACTIVE), .CH_VALID(CH_VALID),
	.CH_INDEX(CH_INDEX), .CH_SYMBOL(CH_SYMBOL));

// ===== testbench/sym_source.sv
// encoder stand-in driving one symbol input port
`timescale 1ns/100ps
module sym_source
#(
	parameter logic [1:0] PORT = 2'h0
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// symbol port
	output logic [9:0] data,
	output logic [4:0] slot,
	output logic valid
);
	logic [4:0] cnt;
	// walks slots 0..31 with random stalls, scrambles lines while idle
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 5'h00;
			data <= 10'h000;
			slot <= 5'h00;
			valid <= 1'b0;
		end
		else if ($urandom_range(3) != 0)
		begin
			valid <= 1'b1;
			slot <= cnt;
			data <= {PORT, cnt, 3'h5};
			cnt <= cnt + 5'h01;
		end
		else
		begin
			valid <= 1'b0;
			slot <= ~slot;
			data <= ~data;
		end
	end
endmodule

// ===== testbench/full_bandwidth_channel_test_tb.sv
// self-checking bench for the full-bandwidth channel test block
`timescale 1ns/100ps
module full_bandwidth_channel_test_tb;
	import fbt_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] addr = 12'h000;
	logic [DATA_W-1:0] wr_data = 16'h0000;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [DATA_W-1:0] rd_data;
	logic [SYM_W-1:0] sdata [4];
	logic [SLOT_W-1:0] sslot [4];
	logic svalid [4];
	logic test_active;
	logic ch_valid;
	logic [CHAN_W-1:0] ch_index;
	logic [SYM_W-1:0] ch_symbol;
	logic [PSEUDO_RANDOM_SEQUENCE_W-1:0] lfsr;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	// free-running 250 MHz clock
	always #2 mclk = ~mclk;
	for (genvar i = 0; i < 4; i++)
	begin : src
		sym_source #(.PORT(2'(i))) m (.clk(mclk), .rst_n(rst_n), .data(sdata[i]), .slot(sslot[i]), .valid(svalid[i]));
	end
	full_bandwidth_channel_test dut (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en),
		.RD_EN(rd_en), .RD_DATA(rd_data), .SYM_DATA_A(sdata[0]), .SYM_SLOT_A(sslot[0]), .SYM_VALID_A(svalid[0]),
		.SYM_DATA_B(sdata[1]), .SYM_SLOT_B(sslot[1]), .SYM_VALID_B(svalid[1]), .SYM_DATA_C(sdata[2]),
		.SYM_SLOT_C(sslot[2]), .SYM_VALID_C(svalid[2]), .SYM_DATA_D(sdata[3]), .SYM_SLOT_D(sslot[3]),
		.SYM_VALID_D(svalid[3]), .TEST_ACTIVE(test_active), .CH_VALID(ch_valid), .CH_INDEX(ch_index),
		.CH_SYMBOL(ch_symbol));
	task automatic check_reg(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_ch(input logic [CHAN_W-1:0] idx, input logic [SYM_W-1:0] sym);
		total_checks++;
		if ({ch_valid, ch_index, ch_symbol} !== {1'b1, idx, sym})
		begin
			errors++;
			$display("[FAIL] %0t channel %h symbol %h expected %h", $time, ch_index, ch_symbol, sym);
		end
	endtask
	// next pseudo random value, shift left with feedback from the two top bits
	function automatic logic [PSEUDO_RANDOM_SEQUENCE_W-1:0] lfsr_step(input logic [PSEUDO_RANDOM_SEQUENCE_W-1:0] s);
		return {s[PSEUDO_RANDOM_SEQUENCE_W-2:0], s[PSEUDO_RANDOM_SEQUENCE_W-1] ^ s[PSEUDO_RANDOM_SEQUENCE_W-2]};
	endfunction
	// symbol the encoder stand-in sends for channel i of port p, group g
	function automatic logic [SYM_W-1:0] stream_symbol(input logic [1:0] p, input logic [1:0] g, input int i);
		return {p, g, 3'(i), 3'h5};
	endfunction
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask
	task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1;
		check_reg(rd_data, exp);
	endtask
	// waits for the run, then checks n channels against the expected source
	task automatic run_chk(input int n, input logic [1:0] p, input logic [1:0] g, input logic pseudo_random_sequence);
		int w;
		w = 0;
		lfsr = PSEUDO_RANDOM_SEQUENCE_SEED;
		repeat (3) @(posedge mclk);
		#1;
		while (ch_valid !== 1'b1 && w < 400)
		begin
			@(posedge mclk);
			#1;
			w++;
		end
		for (int i = 0; i < n; i++)
		begin
			check_ch(7'(i), pseudo_random_sequence ? lfsr[SYM_W-1:0] : stream_symbol(p, g, i));
			lfsr = lfsr_step(lfsr);
			@(posedge mclk);
			#1;
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
		begin
			$display("STATUS OK");
		end
		else
		begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// cuts a hang short
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			give_verdict();
		end
	end
	// scenario sequence
	initial
	begin
		logic [DATA_W-1:0] v;
		v = 16'($urandom(32'hacee));
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		rd_check(TEST_CTRL_OFFSET, 16'h0000);
		rd_check(SOURCE_CTRL_OFFSET, 16'h0000);
		rd_check(12'h7a5, 16'h0000);
		$display("reset test done");
		for (int i = 0; i < 4; i++)
		begin
			v = (i == 0) ? 16'hcfff : (i == 1) ? 16'he00f : 16'($urandom);
			if (v[15:12] == 4'hd)
			begin
				v[15:12] = 4'h6;
			end
			wr(TEST_CTRL_OFFSET, v);
			rd_check(TEST_CTRL_OFFSET, v & 16'hf00f);
			repeat (6) @(posedge mclk);
			#1;
			check_reg({14'h0000, test_active, ch_valid}, 16'h0000);
		end
		$display("locked test done");
		wr(SOURCE_CTRL_OFFSET, 16'h0000);
		wr(TEST_CTRL_OFFSET, 16'hd000);
		run_chk(130, 2'h0, 2'h0, 1'b1);
		check_reg({15'h0000, test_active}, 16'h0001);
		rd_check(STATUS_OFFSET, 16'h0005);
		wr(TEST_CTRL_OFFSET, 16'h5000);
		repeat (3) @(posedge mclk);
		#1;
		check_reg({14'h0000, test_active, ch_valid}, 16'h0000);
		$display("random sequence test done");
		wr(SOURCE_CTRL_OFFSET, 16'hfff1);
		rd_check(SOURCE_CTRL_OFFSET, 16'h0001);
		for (int p = 0; p < 4; p++)
		begin
			for (int g = 0; g < 4; g++)
			begin
				wr(TEST_CTRL_OFFSET, {4'hd, 8'h00, 2'(p), 2'(g)});
				run_chk(16, 2'(p), 2'(g), 1'b0);
				rd_check(STATUS_OFFSET, 16'h07fd);
			end
		end
		$display("stream test done");
		// reset while running must clear the registers and stop the channels
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		rd_check(TEST_CTRL_OFFSET, 16'h0000);
		rd_check(SOURCE_CTRL_OFFSET, 16'h0000);
		check_reg({14'h0000, test_active, ch_valid}, 16'h0000);
		$display("mid-run reset test done");
		give_verdict();
	end
endmodule
